// >>> test/pmcs_osc_model.sv
`timescale 1ns/1ps
// oscillator pins as the core side sees them, synchronous to clk
module pmcs_osc_model
#(
   parameter int HHALF = 2,
   parameter int LHALF = 8
)
(
   // clock
   input wire logic clk,
   // run requests
   input wire logic high_en,
   input wire logic low_en,
   // waveforms
   output logic high_pin = 1'b0,
   output logic low_pin = 1'b0
);
   int hc = 0;
   int lc = 0;

   // a stopped oscillator parks low, so no stale edge survives a restart
   always @(posedge clk)
   begin
      hc <= (hc == HHALF - 1) ? 0 : hc + 1;
      lc <= (lc == LHALF - 1) ? 0 : lc + 1;
      if (!high_en)
         high_pin <= 1'b0;
      else if (hc == HHALF - 1)
         high_pin <= ~high_pin;
      if (!low_en)
         low_pin <= 1'b0;
      else if (lc == LHALF - 1)
         low_pin <= ~low_pin;
   end
endmodule

// >>> test/power_mode_clock_selector_bench.sv
`timescale 1ns/1ps
module power_mode_clock_selector_bench;
   import pmcs_pkg::*;
   logic clk, resetn, reg_wr, reg_rd, halt, wake, keep, lvd, wen, wsrc, ce_in;
   logic [1:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rv;
   logic high_osc_pin, low_osc_pin, high_osc_en, low_osc_en, wdt_run, irq;
   logic [2:0] c, k;
   logic h;
   logic [31:0] rs;
   pmcs_ticks_s ticks;
   pmcs_mode_e mode;
   pmcs_osc_e osc;
   int fail_count, checked, ncpu, nwdt, nsub, nper, ntbc, e;
   // {idle, keep, detect, watchdog, sub source}
   logic [4:0] cfg [6] = '{5'h12, 5'h13, 5'h1a, 5'h04, 5'h03, 5'h00};
   // {watchdog ticking, high en, low en, mode}
   logic [8:0] ex [6] = '{9'h044, 9'h144, 9'h1c8, 9'h060, 9'h160, 9'h010};

   pmcs_selector u_dut (.clk(clk), .resetn(resetn), .ce(ce_in), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .halt(halt), .wake(wake), .peripheral_clock_keep(keep),
      .low_voltage_detect_enable(lvd), .wdt_enable(wen), .wdt_src_sub(wsrc),
      .osc_type(osc), .high_osc_pin(high_osc_pin), .low_osc_pin(low_osc_pin),
      .high_osc_en(high_osc_en), .low_osc_en(low_osc_en), .ticks(ticks),
      .wdt_run(wdt_run), .mode(mode), .irq(irq));

   pmcs_osc_model u_osc (.clk(clk), .high_en(high_osc_en), .low_en(low_osc_en),
      .high_pin(high_osc_pin), .low_pin(low_osc_pin));

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk)
   begin
      if (ticks.cpu === 1'b1)
         ncpu++;
      if (ticks.wdt === 1'b1)
         nwdt++;
      if (ticks.sub === 1'b1)
         nsub++;
      if (ticks.periph === 1'b1)
         nper++;
      if (ticks.tbc === 1'b1)
         ntbc++;
   end

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   task chk(input logic [8:0] seen, input logic [8:0] exp, input string nm);
      checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   // read data stand only in the cycle after the strobe
   task rd(input logic [1:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask

   task pulse(input logic hl);
      @(posedge clk);
      halt <= hl;
      wake <= ~hl;
      @(posedge clk);
      halt <= 1'b0;
      wake <= 1'b0;
      #1;
   endtask

   task final_report;
      $display("checks %0d failures %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      repeat (60000) @(posedge clk);
      fail_count++;
      final_report;
   end

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      {resetn, reg_wr, reg_rd, halt, wake, keep, lvd, wen, wsrc} = '0;
      ce_in = 1'b1;
      osc = PMCS_OSC_INT_RC;
      reg_addr = 2'h0;
      reg_wdata = 8'h00;
      rs = 32'h2170;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      rd(PMCS_ADDR_SMC);
      chk(rv, PMCS_SMC_RESET, "control reset");
      rd(PMCS_ADDR_STAT);
      chk(rv, 9'h0, "status reset");
      rd(PMCS_ADDR_MASK);
      chk(rv, 9'h0, "mask reset");
      rs = xs(rs);
      wr(2'h3, rs[7:0]);
      rd(2'h3);
      chk(rv, 9'h0, "unmapped");
      repeat (200) @(posedge clk);
      // ready flags must survive a write of 8'h01, which has zeros in their bits
      wr(PMCS_ADDR_SMC, 8'h01);
      rd(PMCS_ADDR_SMC);
      chk(rv, 9'h0d, "ready flags");
      wr(PMCS_ADDR_MASK, 8'h04);
      $display("test registers done");
      for (int i = 0; i < 6; i++)
      begin
         wr(PMCS_ADDR_SMC, {6'h00, cfg[i][4], 1'b1});
         {keep, lvd, wen, wsrc} <= cfg[i][3:0];
         pulse(1'b1);
         chk(mode, ex[i][5:0], "halt mode");
         chk({high_osc_en, low_osc_en}, ex[i][7:6], "osc run");
         chk(wdt_run, cfg[i][1] & ~ex[i][4], "watchdog run");
         // the tick launched at the halt edge still belongs to the running mode
         @(posedge clk);
         #1;
         ncpu = 0;
         nwdt = 0;
         nsub = 0;
         nper = 0;
         ntbc = 0;
         repeat (256) @(posedge clk);
         #1;
         chk(ncpu[8:0], 9'h0, "cpu stopped");
         chk(nwdt != 0, ex[i][8], "watchdog ticks");
         chk(nsub != 0, ex[i][6], "sub ticks");
         chk(nper != 0, ex[i][3], "periph ticks");
         chk(ntbc != 0, ex[i][2] | ex[i][3], "timebase ticks");
         pulse(1'b0);
         chk(mode, PMCS_NORMAL, "wake mode");
         chk(irq, 1'b1, "wake irq");
         rd(PMCS_ADDR_SMC);
         chk({rv[2], rv[3]}, ex[i][7:6], "ready at wake");
         wr(PMCS_ADDR_STAT, 8'h07);
         chk(irq, 1'b0, "irq cleared");
         repeat (300) @(posedge clk);
      end
      $display("test modes done");
      rs = xs(rs);
      k = rs[2:0];
      for (int i = 0; i < 9; i++)
      begin
         c = i[2:0] ^ k;
         h = (i == 8);
         wr(PMCS_ADDR_SMC, {c, 4'h0, h});
         repeat (400) @(posedge clk);
         ncpu = 0;
         repeat (2048) @(posedge clk);
         #1;
         e = h ? 512 : (c < 2 ? 128 : 256 >> (7 - c));
         chk(ncpu >= e - 2 && ncpu <= e + 2, 1'b1, "cpu rate");
         chk(mode, (c < 2 && !h) ? PMCS_SLOW : PMCS_NORMAL, "run mode");
         chk(high_osc_en, !(c < 2 && !h), "high osc");
      end
      $display("test divider done");
      // writes while the enable is low must not land
      @(posedge clk);
      ce_in <= 1'b0;
      wr(PMCS_ADDR_SMC, 8'h00);
      @(posedge clk);
      ce_in <= 1'b1;
      rd(PMCS_ADDR_SMC);
      chk(rv, {k, 5'h0d}, "frozen write");
      $display("test enable done");
      // oscillator kind is static, so it changes only under reset
      @(posedge clk);
      resetn <= 1'b0;
      osc <= PMCS_OSC_CRYSTAL;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      rd(PMCS_ADDR_SMC);
      chk(rv, PMCS_SMC_RESET, "second reset");
      wr(PMCS_ADDR_SMC, 8'h13);
      pulse(1'b1);
      chk(mode, PMCS_STOP_IDLE, "crystal idle");
      repeat (50) @(posedge clk);
      pulse(1'b0);
      chk(mode, PMCS_NORMAL, "crystal wake");
      ncpu = 0;
      repeat (1024) @(posedge clk);
      #1;
      chk(ncpu >= 62 && ncpu <= 66, 1'b1, "fast wake rate");
      rd(PMCS_ADDR_SMC);
      chk(rv[2], 1'b0, "crystal not ready");
      repeat (3300) @(posedge clk);
      rd(PMCS_ADDR_SMC);
      chk(rv[2], 1'b1, "crystal ready");
      $display("test fast wake done");
      final_report;
   end
endmodule

// >>> verilog/pmcs_pkg.sv
package pmcs_pkg;
   // register indices on the 2-bit port
   localparam logic [1:0] PMCS_ADDR_SMC = 2'h0;
   localparam logic [1:0] PMCS_ADDR_STAT = 2'h1;
   localparam logic [1:0] PMCS_ADDR_MASK = 2'h2;
   localparam logic [7:0] PMCS_SMC_RESET = 8'h03;
   // field positions of system_mode_control
   localparam int PMCS_CKS_LSB = 5;
   localparam int PMCS_FAST_BIT = 4;
   localparam int PMCS_LRDY_BIT = 3;
   localparam int PMCS_HRDY_BIT = 2;
   localparam int PMCS_IDLE_BIT = 1;
   localparam int PMCS_HSEL_BIT = 0;
   // interrupt status bits
   localparam int PMCS_IRQ_HRDY = 0;
   localparam int PMCS_IRQ_LRDY = 1;
   localparam int PMCS_IRQ_WAKE = 2;
   localparam logic [2:0] PMCS_IRQ_RESET = 3'h0;
   // oscillator settle counts, in oscillator cycles, then watchdog system tick divide minus one
   localparam logic [10:0] PMCS_XTAL_CYC = 11'h400;
   localparam logic [10:0] PMCS_RC_CYC = 11'h010;
   localparam logic [1:0] PMCS_LOW_CYC = 2'h2;
   localparam logic [1:0] PMCS_WDT_SYS_DIV = 2'h3;
   // high clock divide minus one, per selector code
   localparam logic [5:0] PMCS_DIV64 = 6'h3f;
   localparam logic [5:0] PMCS_DIV32 = 6'h1f;
   localparam logic [5:0] PMCS_DIV16 = 6'h0f;
   localparam logic [5:0] PMCS_DIV8 = 6'h07;
   localparam logic [5:0] PMCS_DIV4 = 6'h03;
   localparam logic [5:0] PMCS_DIV2 = 6'h01;
   localparam logic [5:0] PMCS_DIV1 = 6'h00;

   typedef enum logic [1:0]
   {
      PMCS_OSC_CRYSTAL = 2'h0,
      PMCS_OSC_EXT_RC = 2'h1,
      PMCS_OSC_INT_RC = 2'h2
   } pmcs_osc_e;

   typedef enum logic [5:0]
   {
      PMCS_NORMAL = 6'h01,
      PMCS_SLOW = 6'h02,
      PMCS_STOP_IDLE = 6'h04,
      PMCS_RUN_IDLE = 6'h08,
      PMCS_DEEP_SLEEP = 6'h10,
      PMCS_LIGHT_SLEEP = 6'h20
   } pmcs_mode_e;

   typedef struct packed
   {
      logic [2:0] clock_divider_select;
      logic fast_wake_enable;
      logic idle_select;
      logic high_clock_select;
   } pmcs_ctrl_s;

   typedef struct packed
   {
      logic cpu;
      logic periph;
      logic sub;
      logic wdt;
      logic tbc;
   } pmcs_ticks_s;
endpackage

// >>> verilog/pmcs_selector.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Operation
// - normal mode: high clock divided 1..64
// - slow mode: low oscillator, high clock off
// - deep sleep stops cpu, sub, watchdog
// - deep sleep refused while voltage detect on
// - light sleep keeps sub/watchdog when needed
// - idle, no keep: stopped idle, oscillator off
// - stopped idle: watchdog clock follows source
// - idle with keep: running idle, clock on
// - halt: idle select picks idle or sleep
// - divider field maps low, /64 .. /2
// - high select uses undivided high clock
// - switching to low stops high clock
// - fast wake only with crystal oscillator
// - low ready: low in deep, 2 cycles
// - high ready: cleared off, 1024 or 16
// - sleep deep only if watchdog, detect off
// - fast wake runs sub until ready
module pmcs_selector
   import pmcs_pkg::*;
(
   // clock, reset, enable
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // register port
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // core and configuration
   input wire logic halt,
   input wire logic wake,
   input wire logic peripheral_clock_keep,
   input wire logic low_voltage_detect_enable,
   input wire logic wdt_enable,
   input wire logic wdt_src_sub,
   input wire pmcs_osc_e osc_type,
   // oscillator pins
   input wire logic high_osc_pin,
   input wire logic low_osc_pin,
   output logic high_osc_en,
   output logic low_osc_en,
   // clock enables and status
   output pmcs_ticks_s ticks,
   output logic wdt_run,
   output pmcs_mode_e mode,
   output logic irq
);

   pmcs_mode_e mode_r, mode_nxt;
   pmcs_ctrl_s ctrl_r, ctrl_nxt;
   pmcs_ticks_s ticks_r, ticks_nxt;
   logic [2:0] hs_r, hs_nxt, ls_r, ls_nxt;
   logic [3:0] eff_r, eff_nxt;
   logic [5:0] div_r, div_nxt;
   logic [10:0] hcnt_r, hcnt_nxt;
   logic [1:0] lcnt_r, lcnt_nxt, w4_r, w4_nxt;
   logic hrdy_r, hrdy_nxt, lrdy_r, lrdy_nxt, fw_r, fw_nxt;
   logic [2:0] stat_r, stat_nxt, mask_r, mask_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic htick, ltick, req_low, eff_low, running, sys_tick;
   logic hi_en, lo_en, sub_tick, wdt_tick, cpu_tick;
   logic [5:0] ratio;
   logic [10:0] htarget;
   logic sys_on;

   //////////////////////////////////////////////////////////////////////////////
   // oscillator edges: pins are asynchronous, third stage only for the edge
   always_comb
   begin
      hs_nxt = {hs_r[1:0], high_osc_pin};
      ls_nxt = {ls_r[1:0], low_osc_pin};
   end

   assign htick = ce & hs_r[1] & ~hs_r[2];
   assign ltick = ce & ls_r[1] & ~ls_r[2] & lo_en;

   //////////////////////////////////////////////////////////////////////////////
   // source selection and divider
   function automatic logic [5:0] div_of(input logic [3:0] sel);
      logic [5:0] r;
      r = PMCS_DIV1;
      if (!sel[3])
      begin
         unique case (sel[2:0])
            3'h2: r = PMCS_DIV64;
            3'h3: r = PMCS_DIV32;
            3'h4: r = PMCS_DIV16;
            3'h5: r = PMCS_DIV8;
            3'h6: r = PMCS_DIV4;
            3'h7: r = PMCS_DIV2;
            default: r = PMCS_DIV1;
         endcase
      end
      return r;
   endfunction

   // {high select, divider field}; low clock when high select is 0 and field is 000 or 001
   assign req_low = ~ctrl_r.high_clock_select & (ctrl_r.clock_divider_select[2:1] == 2'h0);
   assign eff_low = ~eff_r[3] & (eff_r[2:1] == 2'h0);
   assign ratio = div_of(eff_r);
   assign running = (mode_r == PMCS_NORMAL) | (mode_r == PMCS_SLOW);
   // system clock is dead in stopped idle and sleep, even from the low source
   assign sys_on = running | (mode_r == PMCS_RUN_IDLE);
   // high ticks count only once the oscillator is stable
   assign sys_tick = sys_on & (eff_low ? ltick : (htick & hrdy_r & (div_r == ratio)));
   assign cpu_tick = running & (fw_r ? ltick : sys_tick);
   assign htarget = (osc_type == PMCS_OSC_CRYSTAL) ? PMCS_XTAL_CYC : PMCS_RC_CYC;

   // high oscillator stays up until the switch lands on a tick boundary
   assign hi_en = (running | (mode_r == PMCS_RUN_IDLE)) & (~req_low | ~eff_low);
   assign lo_en = (mode_r != PMCS_DEEP_SLEEP) &
                  ~((mode_r == PMCS_LIGHT_SLEEP) &
                    ~(low_voltage_detect_enable | (wdt_enable & wdt_src_sub)));
   assign sub_tick = ltick;
   assign wdt_tick = wdt_run & (wdt_src_sub ? sub_tick : (sys_tick & (w4_r == PMCS_WDT_SYS_DIV)));

   always_comb
   begin
      eff_nxt = eff_r;
      div_nxt = div_r;
      w4_nxt = w4_r;
      // while the clock runs, a new selection only takes over at the end of a whole period; when stopped it takes over at once
      if (!(running | (mode_r == PMCS_RUN_IDLE)))
         eff_nxt = {ctrl_r.high_clock_select, ctrl_r.clock_divider_select};
      else if (sys_tick & (req_low | hrdy_r))
         eff_nxt = {ctrl_r.high_clock_select, ctrl_r.clock_divider_select};
      if (sys_tick | eff_low | ~hrdy_r)
         div_nxt = 6'h00;
      else if (htick)
         div_nxt = div_r + 6'h01;
      if (sys_tick)
         w4_nxt = w4_r + 2'h1;
   end

   //////////////////////////////////////////////////////////////////////////////
   // mode machine
   always_comb
   begin
      mode_nxt = mode_r;
      fw_nxt = fw_r;
      if (hrdy_r | ~running)
         fw_nxt = 1'b0;
      unique case (mode_r)
         PMCS_NORMAL, PMCS_SLOW:
         begin
            if (halt & ce)
            begin
               if (ctrl_r.idle_select)
                  mode_nxt = peripheral_clock_keep ? PMCS_RUN_IDLE : PMCS_STOP_IDLE;
               else if (low_voltage_detect_enable | wdt_enable)
                  mode_nxt = PMCS_LIGHT_SLEEP;
               else
                  mode_nxt = PMCS_DEEP_SLEEP;
            end
            else
               mode_nxt = eff_low ? PMCS_SLOW : PMCS_NORMAL;
         end
         PMCS_STOP_IDLE, PMCS_RUN_IDLE, PMCS_DEEP_SLEEP, PMCS_LIGHT_SLEEP:
         begin
            if (wake & ce)
            begin
               mode_nxt = req_low ? PMCS_SLOW : PMCS_NORMAL;
               // sub clock is dead after deep sleep, so no fast start there
               fw_nxt = ctrl_r.fast_wake_enable & ~req_low & (osc_type == PMCS_OSC_CRYSTAL) &
                        ((mode_r == PMCS_LIGHT_SLEEP) | (mode_r == PMCS_STOP_IDLE));
            end
         end
         default:
            mode_nxt = PMCS_NORMAL;
      endcase
   end

   //////////////////////////////////////////////////////////////////////////////
   // ready flags
   always_comb
   begin
      hcnt_nxt = hcnt_r;
      hrdy_nxt = hrdy_r;
      lcnt_nxt = lcnt_r;
      lrdy_nxt = lrdy_r;
      if (!hi_en)
      begin
         hcnt_nxt = 11'h000;
         hrdy_nxt = 1'b0;
      end
      else if (htick & ~hrdy_r)
      begin
         hcnt_nxt = hcnt_r + 11'h001;
         hrdy_nxt = (hcnt_r == htarget - 11'h001);
      end
      if (!lo_en)
      begin
         lcnt_nxt = 2'h0;
         lrdy_nxt = 1'b0;
      end
      else if (ltick & ~lrdy_r)
      begin
         lcnt_nxt = lcnt_r + 2'h1;
         lrdy_nxt = (lcnt_r == PMCS_LOW_CYC - 2'h1);
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // registers and interrupt
   always_comb
   begin
      ctrl_nxt = ctrl_r;
      mask_nxt = mask_r;
      stat_nxt = stat_r;
      rdata_nxt = 8'h00;
      if (reg_wr & ce)
      begin
         unique case (reg_addr)
            PMCS_ADDR_SMC:
            begin
               ctrl_nxt.clock_divider_select = reg_wdata[PMCS_CKS_LSB +: 3];
               ctrl_nxt.fast_wake_enable = reg_wdata[PMCS_FAST_BIT];
               ctrl_nxt.idle_select = reg_wdata[PMCS_IDLE_BIT];
               ctrl_nxt.high_clock_select = reg_wdata[PMCS_HSEL_BIT];
            end
            PMCS_ADDR_STAT: stat_nxt = stat_r & ~reg_wdata[2:0];
            PMCS_ADDR_MASK: mask_nxt = reg_wdata[2:0];
            default: ;
         endcase
      end
      // new events win over a same-cycle clear
      stat_nxt[PMCS_IRQ_HRDY] = stat_nxt[PMCS_IRQ_HRDY] | (hrdy_nxt & ~hrdy_r);
      stat_nxt[PMCS_IRQ_LRDY] = stat_nxt[PMCS_IRQ_LRDY] | (lrdy_nxt & ~lrdy_r);
      stat_nxt[PMCS_IRQ_WAKE] = stat_nxt[PMCS_IRQ_WAKE] | (~running & wake & ce);
      if (reg_rd & ce)
      begin
         unique case (reg_addr)
            PMCS_ADDR_SMC:
               rdata_nxt = {ctrl_r.clock_divider_select, ctrl_r.fast_wake_enable,
                            lrdy_r, hrdy_r, ctrl_r.idle_select, ctrl_r.high_clock_select};
            PMCS_ADDR_STAT: rdata_nxt = {5'h00, stat_r};
            PMCS_ADDR_MASK: rdata_nxt = {5'h00, mask_r};
            default: rdata_nxt = 8'h00;
         endcase
      end
      ticks_nxt.cpu = cpu_tick;
      ticks_nxt.periph = sys_tick & (running | (mode_r == PMCS_RUN_IDLE));
      ticks_nxt.sub = sub_tick;
      ticks_nxt.wdt = wdt_tick;
      ticks_nxt.tbc = ltick & (mode_r != PMCS_LIGHT_SLEEP);
   end

   assign wdt_run = wdt_enable & (mode_r != PMCS_DEEP_SLEEP);

   //////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         hs_r <= 3'h0;
         ls_r <= 3'h0;
         mode_r <= PMCS_NORMAL;
         ctrl_r <= {PMCS_SMC_RESET[PMCS_CKS_LSB +: 3], PMCS_SMC_RESET[PMCS_FAST_BIT],
                    PMCS_SMC_RESET[PMCS_IDLE_BIT], PMCS_SMC_RESET[PMCS_HSEL_BIT]};
         eff_r <= 4'h8;
         div_r <= 6'h00;
         w4_r <= 2'h0;
         hcnt_r <= 11'h000;
         hrdy_r <= 1'b0;
         lcnt_r <= 2'h0;
         lrdy_r <= 1'b0;
         fw_r <= 1'b0;
         stat_r <= PMCS_IRQ_RESET;
         mask_r <= PMCS_IRQ_RESET;
         rdata_r <= 8'h00;
         ticks_r <= '0;
      end
      else if (ce)
      begin
         hs_r <= hs_nxt;
         ls_r <= ls_nxt;
         mode_r <= mode_nxt;
         ctrl_r <= ctrl_nxt;
         eff_r <= eff_nxt;
         div_r <= div_nxt;
         w4_r <= w4_nxt;
         hcnt_r <= hcnt_nxt;
         hrdy_r <= hrdy_nxt;
         lcnt_r <= lcnt_nxt;
         lrdy_r <= lrdy_nxt;
         fw_r <= fw_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         rdata_r <= rdata_nxt;
         ticks_r <= ticks_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign high_osc_en = hi_en;
   assign low_osc_en = lo_en;
   assign ticks = ticks_r;
   assign mode = mode_r;
   assign irq = |(stat_r & mask_r);

   //////////////////////////////////////////////////////////////////////////////
   a_slow_high_off: assert property (@(posedge clk) disable iff (!resetn)
      (mode_r == PMCS_SLOW) && req_low |-> !high_osc_en)
      else $error("high clock running in slow mode");
   a_deep_all_off: assert property (@(posedge clk) disable iff (!resetn)
      (mode_r == PMCS_DEEP_SLEEP) |=> !ticks.sub && !ticks.wdt && !ticks.cpu && !wdt_run)
      else $error("clock running in deep sleep");
   a_deep_needs_off: assert property (@(posedge clk) disable iff (!resetn)
      $changed(mode_r) && (mode_r == PMCS_DEEP_SLEEP)
         |-> $past(!low_voltage_detect_enable && !wdt_enable))
      else $error("deep sleep entered with detect or watchdog on");
   a_halt_idle_pick: assert property (@(posedge clk) disable iff (!resetn)
      ce && halt && running && ctrl_r.idle_select
         |=> mode_r == ($past(peripheral_clock_keep) ? PMCS_RUN_IDLE : PMCS_STOP_IDLE))
      else $error("halt did not enter the chosen idle mode");
   a_stop_idle_wdt: assert property (@(posedge clk) disable iff (!resetn)
      (mode_r == PMCS_STOP_IDLE) && !wdt_src_sub |=> !ticks.wdt)
      else $error("watchdog clock in stopped idle from system source");
   a_high_rdy_clear: assert property (@(posedge clk) disable iff (!resetn)
      (mode_r inside {PMCS_STOP_IDLE, PMCS_DEEP_SLEEP, PMCS_LIGHT_SLEEP}) |=> !hrdy_r)
      else $error("high ready set with oscillator stopped");
   a_low_rdy_deep: assert property (@(posedge clk) disable iff (!resetn)
      (mode_r == PMCS_DEEP_SLEEP) |=> !lrdy_r)
      else $error("low ready set in deep sleep");
   a_cpu_halted: assert property (@(posedge clk) disable iff (!resetn)
      !running |=> !ticks.cpu)
      else $error("cpu clock while halted");
   a_undivided: assert property (@(posedge clk) disable iff (!resetn)
      running && eff_r[3] && hrdy_r && htick && !fw_r |=> ticks.cpu)
      else $error("high select did not pass every high tick");
   a_fast_wake_sub: assert property (@(posedge clk) disable iff (!resetn)
      running && fw_r && ltick |=> ticks.cpu)
      else $error("fast wake did not run from sub clock");
   a_light_sub_keep: assert property (@(posedge clk) disable iff (!resetn)
      (mode_r == PMCS_LIGHT_SLEEP) && (low_voltage_detect_enable || (wdt_enable && wdt_src_sub))
         |-> low_osc_en)
      else $error("sub clock stopped in light sleep while needed");
   a_stop_idle_osc: assert property (@(posedge clk) disable iff (!resetn)
      (mode_r == PMCS_STOP_IDLE) |-> !high_osc_en)
      else $error("system oscillator running in stopped idle");
   a_run_idle_osc: assert property (@(posedge clk) disable iff (!resetn)
      (mode_r == PMCS_RUN_IDLE) && !req_low |-> high_osc_en)
      else $error("system oscillator stopped in running idle");
   a_sleep_pick: assert property (@(posedge clk) disable iff (!resetn)
      ce && halt && running && !ctrl_r.idle_select
         |=> mode_r == ($past(low_voltage_detect_enable || wdt_enable) ?
                        PMCS_LIGHT_SLEEP : PMCS_DEEP_SLEEP))
      else $error("halt did not enter the chosen sleep mode");
   a_slow_select: assert property (@(posedge clk) disable iff (!resetn)
      ce && running && eff_low && !halt |=> mode_r == PMCS_SLOW)
      else $error("low clock selected but not in slow mode");
   a_high_off_low: assert property (@(posedge clk) disable iff (!resetn)
      eff_low && req_low |-> !high_osc_en)
      else $error("high clock left on after switch to low clock");
   a_high_rdy_count: assert property (@(posedge clk) disable iff (!resetn)
      $rose(hrdy_r) |-> $past(hcnt_r) == htarget - 11'h001)
      else $error("high ready rose at the wrong count");
   a_low_rdy_count: assert property (@(posedge clk) disable iff (!resetn)
      $rose(lrdy_r) |-> $past(lcnt_r) == PMCS_LOW_CYC - 2'h1)
      else $error("low ready rose at the wrong count");
   a_fast_wake_xtal: assert property (@(posedge clk) disable iff (!resetn)
      $rose(fw_r) |-> $past((osc_type == PMCS_OSC_CRYSTAL) && ctrl_r.fast_wake_enable))
      else $error("fast wake started without crystal and enable");
   a_stop_idle_sub: assert property (@(posedge clk) disable iff (!resetn)
      (mode_r == PMCS_STOP_IDLE) && wdt_enable && wdt_src_sub && ltick |=> ticks.wdt)
      else $error("watchdog clock missing in stopped idle from sub source");
   a_no_unready_tick: assert property (@(posedge clk) disable iff (!resetn)
      ce && running && !eff_low && !hrdy_r && !fw_r |=> !ticks.cpu)
      else $error("cpu ticked from an unstable high clock");
   a_switch_boundary: assert property (@(posedge clk) disable iff (!resetn)
      $changed(eff_r) |-> $past(sys_tick || !sys_on))
      else $error("clock source changed off a tick boundary");
endmodule
